// [test/nvmem_dev_model.sv]
`timescale 1ns/1ps
module nvmem_dev_model #(
   parameter int DLY = 0
) (
   input wire clk,
   input wire cs_n,
   input wire we_n,
   input wire oe_n,
   input wire hi_n,
   input wire lo_n,
   input wire sleep_n,
   input wire [16:0] addr,
   input wire [15:0] din,
   output logic [15:0] dq
);
   logic [15:0] mem [0:131071];
   logic [7:0] pat = 8'h5A;
   // Slow turn-on, instant release
   wire #(DLY) oe_late = !oe_n;
   wire act = sleep_n && !cs_n;
   always @(posedge clk) pat <= ~pat;
   always @(posedge we_n) begin
      if (act) begin
         if (!hi_n) mem[addr][15:8] <= din[15:8];
         if (!lo_n) mem[addr][7:0] <= din[7:0];
      end
   end
   always @* begin
      dq = {pat, ~pat};
      if (act && !oe_n && oe_late && we_n) begin
         if (!hi_n) dq[15:8] = mem[addr][15:8];
         if (!lo_n) dq[7:0] = mem[addr][7:0];
      end
   end
endmodule // nvmem_dev_model

// [test/nvmem_host_checker.sv]
`timescale 1ns/1ps
`include "nvmem_host_defs.vh"
module nvmem_host_checker #(
   parameter POWERUP_CYC = 20,
   parameter WAKE_CYC = 20
) (
   input wire CLK,
   input wire SYS_RST,
   input wire CHIP_SELECT_N,
   input wire WRITE_STROBE_N,
   input wire UPPER_LANE_SELECT_N,
   input wire LOWER_LANE_SELECT_N,
   input wire SLEEP_REQUEST_N,
   input wire [`ADDR_W-1:0] ADDRESS,
   input wire DATA_OE_N
);
   int up_r, wk_r, sl_r;
   // Saturate up_r and wk_r so long runs never wrap; sl_r is not saturated
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         up_r <= 0;
         wk_r <= 1 << 20;
         sl_r <= 0;
      end else begin
         up_r <= (up_r < (1 << 20)) ? up_r + 1 : up_r;
         wk_r <= !SLEEP_REQUEST_N ? 0 : ((wk_r < (1 << 20)) ? wk_r + 1 : wk_r);
         sl_r <= SLEEP_REQUEST_N ? 0 : sl_r + 1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   chk_powerup_wait: assert property ($fell(CHIP_SELECT_N) |-> up_r >= POWERUP_CYC)
      else $error("access before power-up wait");
   chk_wake_wait: assert property ($fell(CHIP_SELECT_N) |-> wk_r >= WAKE_CYC)
      else $error("access before wake wait");
   chk_sleep_low: assert property ($rose(SLEEP_REQUEST_N) |-> sl_r >= `SLEEP_LOW_CYC)
      else $error("sleep pulse too short");
   chk_asleep_quiet: assert property (!SLEEP_REQUEST_N |-> CHIP_SELECT_N && DATA_OE_N)
      else $error("bus active while asleep");
   chk_lane_setup: assert property ($fell(WRITE_STROBE_N) |->
      $stable({UPPER_LANE_SELECT_N, LOWER_LANE_SELECT_N}) && !CHIP_SELECT_N)
      else $error("lanes moved at strobe fall");
   chk_lane_hold: assert property ($rose(WRITE_STROBE_N) |=>
      ($past(UPPER_LANE_SELECT_N) -> UPPER_LANE_SELECT_N) &&
      ($past(LOWER_LANE_SELECT_N) -> LOWER_LANE_SELECT_N))
      else $error("masked lane dropped after strobe");
   chk_lanes_release: assert property ($rose(CHIP_SELECT_N) |->
      UPPER_LANE_SELECT_N && LOWER_LANE_SELECT_N)
      else $error("lanes left active");
   chk_col_stable: assert property (!CHIP_SELECT_N && $changed(ADDRESS[1:0]) |=>
      $stable(ADDRESS[1:0]) || CHIP_SELECT_N)
      else $error("column bits unstable");
   cover property ($rose(WRITE_STROBE_N));
   cover property ($rose(SLEEP_REQUEST_N));
   cover property (!CHIP_SELECT_N && $changed(ADDRESS[1:0]));
endmodule // nvmem_host_checker

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst = 1, vld = 0, wr = 0, pg = 0, slp = 0;
   logic [16:0] adr = 0;
   logic [15:0] wd = 0;
   logic [1:0] ln = 2'h3;
   logic [15:0] sh [0:7];
   wire rdy, rv, slept, cs, we, oe, hs, ls, slpn, doe;
   wire [16:0] pa;
   wire [15:0] rd, din, dout;
   int errors = 0, num_checks = 0, w, i;
   initial forever #12.5 clk = ~clk;
   nvmem_host #(.POWERUP_CYC(20), .WAKE_CYC(20)) u_nvmem_host (.CLK(clk), .SYS_RST(rst),
      .REQ_VALID(vld), .REQ_WRITE(wr), .REQ_PAGE(pg), .REQ_ADDR(adr), .REQ_WDATA(wd),
      .REQ_LANES(ln), .SLEEP_REQ(slp), .REQ_READY(rdy), .RSP_VALID(rv), .RSP_RDATA(rd),
      .ASLEEP(slept), .CHIP_SELECT_N(cs), .WRITE_STROBE_N(we), .OUTPUT_DRIVE_N(oe),
      .UPPER_LANE_SELECT_N(hs), .LOWER_LANE_SELECT_N(ls), .SLEEP_REQUEST_N(slpn),
      .ADDRESS(pa), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(doe));
   nvmem_dev_model #(.DLY(60)) u_nvmem_dev_model (.clk(clk), .cs_n(cs), .we_n(we),
      .oe_n(oe), .hi_n(hs), .lo_n(ls), .sleep_n(slpn), .addr(pa), .din(dout), .dq(din));
   task end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   function logic [15:0] exp_rd(input logic [16:0] a, input logic [1:0] l);
      exp_rd = {l[1] ? sh[{a[16], a[1:0]}][15:8] : 8'h00, l[0] ? sh[{a[16], a[1:0]}][7:0] : 8'h00};
   endfunction
   function logic [16:0] pick(input int r);
      pick = {r[2] ? 15'h7FFF : 15'h0000, r[1:0]};
   endfunction
   task go(input logic w_i, input logic p_i, input logic [16:0] a, input logic [15:0] d,
      input logic [1:0] l);
      @(negedge clk);
      {vld, wr, pg, adr, wd, ln} = {1'b1, w_i, p_i, a, d, l};
      w = 0;
      while (rdy !== 1'b1 && w < 200) begin
         @(negedge clk);
         w++;
      end
      vld = 0;
      chk(w < 200, "request not taken");
      if (w_i) begin
         if (l[1]) sh[{a[16], a[1:0]}][15:8] = d[15:8];
         if (l[0]) sh[{a[16], a[1:0]}][7:0] = d[7:0];
      end else begin
         for (i = 0; i < 60 && rv !== 1'b1; i++) @(negedge clk);
         chk(rv === 1'b1 && rd === exp_rd(a, l), "read data mismatch");
      end
   endtask
   initial begin
      #500000;
      errors++;
      end_sim;
   end
   initial begin
      void'($urandom(69));
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 0;
      go(1, 0, 17'h0_0000, 16'hA5C3, 2'h3);
      chk(w >= 19, "access taken during power-up");
      for (int k = 0; k < 8; k++) go(1, 0, pick(k), 16'($urandom), 2'h3);
      for (int k = 0; k < 40; k++)
         go(1'($urandom), 0, pick($urandom), 16'($urandom), 2'($urandom_range(1, 3)));
      for (int k = 3; k >= 0; k--) go(0, 1, pick(k + 4), 16'h0000, 2'h3);
      go(1, 0, 17'h0_0002, 16'h3C5A, 2'h1);
      @(negedge clk) {slp, vld} = 2'b11;
      for (int k = 0; k < 70; k++) begin
         @(negedge clk);
         if (k > 15) chk(slept === 1'b1 && rdy === 1'b0 && cs === 1'b1, "active asleep");
      end
      {slp, vld} = 2'b00;
      go(0, 0, 17'h0_0002, 16'h0000, 2'h3);
      chk(w >= 19, "access taken during wake");
      end_sim;
   end
endmodule // testbench
bind nvmem_host nvmem_host_checker #(.POWERUP_CYC(POWERUP_CYC), .WAKE_CYC(WAKE_CYC))
   u_nvmem_host_checker (.CLK(CLK), .SYS_RST(SYS_RST), .CHIP_SELECT_N(CHIP_SELECT_N),
   .WRITE_STROBE_N(WRITE_STROBE_N), .UPPER_LANE_SELECT_N(UPPER_LANE_SELECT_N),
   .LOWER_LANE_SELECT_N(LOWER_LANE_SELECT_N), .SLEEP_REQUEST_N(SLEEP_REQUEST_N),
   .ADDRESS(ADDRESS), .DATA_OE_N(DATA_OE_N));

// [verilog/nvmem_host.v]
`timescale 1ns/1ps
// Summary of operation
// - Sleep low 1 us; wait 450 us after
// - Sleep may follow last write immediately
// - Wait 1 ms after power-up before access
// - Column bits stable 15 ns per access
// - Lane selects toggled, never tied active
// - Masked lane high around write strobe
`include "nvmem_host_defs.vh"
module nvmem_host #(
   parameter POWERUP_CYC = `POWERUP_WAIT_CYC,
   parameter WAKE_CYC = `WAKE_WAIT_CYC
) (
   input wire CLK,
   input wire SYS_RST,
   input wire REQ_VALID,
   input wire REQ_WRITE,
   input wire REQ_PAGE,
   input wire [`ADDR_W-1:0] REQ_ADDR,
   input wire [`DATA_W-1:0] REQ_WDATA,
   input wire [1:0] REQ_LANES,
   input wire SLEEP_REQ,
   output reg REQ_READY,
   output reg RSP_VALID,
   output reg [`DATA_W-1:0] RSP_RDATA,
   output reg ASLEEP,
   output reg CHIP_SELECT_N,
   output reg WRITE_STROBE_N,
   output reg OUTPUT_DRIVE_N,
   output reg UPPER_LANE_SELECT_N,
   output reg LOWER_LANE_SELECT_N,
   output reg SLEEP_REQUEST_N,
   output reg [`ADDR_W-1:0] ADDRESS,
   input wire [`DATA_W-1:0] DATA_IN,
   output reg [`DATA_W-1:0] DATA_OUT,
   output reg DATA_OE_N
);
   localparam ST_POWERUP = 3'd0;
   localparam ST_IDLE = 3'd1;
   localparam ST_SETUP = 3'd2;
   localparam ST_STROBE = 3'd3;
   localparam ST_HOLD = 3'd4;
   localparam ST_PRECHG = 3'd5;
   localparam ST_SLEEP = 3'd6;
   localparam ST_WAKE = 3'd7;
   localparam TW = 20;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg wr_r;
   reg pu_loaded_r;
   reg [`DATA_W-1:0] din_s1_r;
   reg [`DATA_W-1:0] din_s2_r;
   reg tload;
   reg [TW-1:0] tcount;
   wire tdone;

   function [TW-1:0] cyc;
      input integer n;
      begin
         cyc = n[TW-1:0];
      end
   endfunction

   wait_timer #(.W(TW)) u_timer (
      .clk(CLK),
      .rst(SYS_RST),
      .load(tload),
      .count(tcount),
      .done(tdone)
   );

   // Data pins come from the device's clockless domain
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         din_s1_r <= 16'h0000;
         din_s2_r <= 16'h0000;
      end else begin
         din_s1_r <= DATA_IN;
         din_s2_r <= din_s1_r;
      end
   end

   always @* begin
      state_nxt = state_r;
      tload = 1'b0;
      tcount = {TW{1'b0}};
      case (state_r)
         ST_POWERUP: begin
            // Timer leaves reset at zero, so arm it once here
            if (!pu_loaded_r) begin
               tload = 1'b1;
               tcount = cyc(POWERUP_CYC);
            end else if (tdone) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (SLEEP_REQ) begin
               // No gap needed after a finished write
               state_nxt = ST_SLEEP;
               tload = 1'b1;
               tcount = cyc(`SLEEP_LOW_CYC);
            end else if (REQ_VALID) begin
               state_nxt = ST_SETUP;
               tload = 1'b1;
               tcount = cyc(`LANE_SETUP_CYC);
            end
         end
         ST_SETUP: begin
            if (tdone) begin
               state_nxt = ST_STROBE;
               tload = 1'b1;
               // Column bits held over the whole strobe
               tcount = wr_r ? cyc(`STROBE_LOW_CYC) : cyc(`READ_ACCESS_CYC + 2);
            end
         end
         ST_STROBE: begin
            if (tdone) begin
               state_nxt = ST_HOLD;
               tload = 1'b1;
               tcount = cyc(`LANE_HOLD_CYC);
            end
         end
         ST_HOLD: begin
            if (tdone) begin
               if (REQ_VALID && REQ_PAGE && !SLEEP_REQ) begin
                  state_nxt = ST_SETUP;
                  tload = 1'b1;
                  tcount = cyc(`COL_STABLE_CYC);
               end else begin
                  state_nxt = ST_PRECHG;
                  tload = 1'b1;
                  tcount = cyc(`PRECHARGE_CYC);
               end
            end
         end
         ST_PRECHG: begin
            if (tdone) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_SLEEP: begin
            if (tdone && !SLEEP_REQ) begin
               state_nxt = ST_WAKE;
               tload = 1'b1;
               tcount = cyc(WAKE_CYC);
            end
         end
         ST_WAKE: begin
            if (tdone) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_r <= ST_POWERUP;
         wr_r <= 1'b0;
         pu_loaded_r <= 1'b0;
         REQ_READY <= 1'b0;
         RSP_VALID <= 1'b0;
         RSP_RDATA <= 16'h0000;
         ASLEEP <= 1'b0;
         CHIP_SELECT_N <= 1'b1;
         WRITE_STROBE_N <= 1'b1;
         OUTPUT_DRIVE_N <= 1'b1;
         UPPER_LANE_SELECT_N <= 1'b1;
         LOWER_LANE_SELECT_N <= 1'b1;
         SLEEP_REQUEST_N <= 1'b1;
         ADDRESS <= 17'h0_0000;
         DATA_OUT <= 16'h0000;
         DATA_OE_N <= 1'b1;
      end else begin
         state_r <= state_nxt;
         pu_loaded_r <= 1'b1;
         RSP_VALID <= 1'b0;
         REQ_READY <= 1'b0;
         ASLEEP <= (state_nxt == ST_SLEEP);
         SLEEP_REQUEST_N <= (state_nxt != ST_SLEEP);
         // Taking a request: latch address, data and lanes
         if ((state_r == ST_IDLE && state_nxt == ST_SETUP) ||
             (state_r == ST_HOLD && state_nxt == ST_SETUP)) begin
            REQ_READY <= 1'b1;
            wr_r <= REQ_WRITE;
            CHIP_SELECT_N <= 1'b0;
            // Page step changes only column bits
            if (state_r == ST_HOLD) begin
               ADDRESS[`COL_W-1:0] <= REQ_ADDR[`COL_W-1:0];
            end else begin
               ADDRESS <= REQ_ADDR;
            end
            // Masked lane goes high before the strobe
            UPPER_LANE_SELECT_N <= ~REQ_LANES[1];
            LOWER_LANE_SELECT_N <= ~REQ_LANES[0];
            DATA_OUT <= REQ_WDATA;
            DATA_OE_N <= ~REQ_WRITE;
         end
         if (state_nxt == ST_STROBE && state_r == ST_SETUP) begin
            WRITE_STROBE_N <= ~wr_r;
            OUTPUT_DRIVE_N <= wr_r;
         end
         if (state_r == ST_STROBE && state_nxt == ST_HOLD) begin
            WRITE_STROBE_N <= 1'b1;
            OUTPUT_DRIVE_N <= 1'b1;
            if (!wr_r) begin
               RSP_VALID <= 1'b1;
               // Unselected lane floats, so report it as zero
               RSP_RDATA <= {UPPER_LANE_SELECT_N ? 8'h00 : din_s2_r[15:8],
                             LOWER_LANE_SELECT_N ? 8'h00 : din_s2_r[7:0]};
            end
         end
         if (state_nxt == ST_PRECHG) begin
            CHIP_SELECT_N <= 1'b1;
            UPPER_LANE_SELECT_N <= 1'b1;
            LOWER_LANE_SELECT_N <= 1'b1;
            DATA_OE_N <= 1'b1;
         end
         if (state_nxt == ST_SLEEP) begin
            // Device ignores select while asleep; park it high anyway
            CHIP_SELECT_N <= 1'b1;
            DATA_OE_N <= 1'b1;
         end
      end
   end
endmodule // nvmem_host

// [verilog/nvmem_host_defs.vh]
`ifndef NVMEM_HOST_DEFS_VH
`define NVMEM_HOST_DEFS_VH

// Clock period in picoseconds (40 MHz)
`define CLK_PERIOD_PS 25000
// Timing figures in their own units
`define SLEEP_LOW_MIN_US 1
`define WAKE_WAIT_MIN_US 450
`define POWERUP_WAIT_MIN_MS 1
`define COL_STABLE_MIN_NS 15
`define LANE_SETUP_MIN_NS 8
`define LANE_HOLD_MIN_NS 8
`define STROBE_LOW_MIN_NS 22
`define READ_ACCESS_MAX_NS 105
`define PRECHARGE_MIN_NS 35
// Derived cycle counts, least times rounded up
`define CYC_UP(ns) ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SLEEP_LOW_CYC `CYC_UP(`SLEEP_LOW_MIN_US * 1000)
`define WAKE_WAIT_CYC `CYC_UP(`WAKE_WAIT_MIN_US * 1000)
`define POWERUP_WAIT_CYC `CYC_UP(`POWERUP_WAIT_MIN_MS * 1000000)
`define COL_STABLE_CYC `CYC_UP(`COL_STABLE_MIN_NS)
`define LANE_SETUP_CYC `CYC_UP(`LANE_SETUP_MIN_NS)
`define LANE_HOLD_CYC `CYC_UP(`LANE_HOLD_MIN_NS)
`define STROBE_LOW_CYC `CYC_UP(`STROBE_LOW_MIN_NS)
`define READ_ACCESS_CYC `CYC_UP(`READ_ACCESS_MAX_NS)
`define PRECHARGE_CYC `CYC_UP(`PRECHARGE_MIN_NS)
// Bus widths
`define ADDR_W 17
`define DATA_W 16
`define COL_W 2

`endif

// [verilog/wait_timer.v]
`timescale 1ns/1ps
// Down counter: load a count, done stays high once it reaches zero
module wait_timer #(
   parameter W = 16
) (
   input wire clk,
   input wire rst,
   input wire load,
   input wire [W-1:0] count,
   output wire done
);
   reg [W-1:0] cnt_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= {W{1'b0}};
      end else if (load) begin
         cnt_r <= count;
      end else if (cnt_r != {W{1'b0}}) begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign done = (cnt_r == {W{1'b0}});
endmodule // wait_timer
